// [mpp_pkg.sv]
package mpp_pkg;

    ////////////////////////////////////////////////////////////////////
    // sizes
    localparam int unsigned DW   = 32;  // register data width
    localparam int unsigned AW   = 8;   // axi byte address width
    localparam int unsigned NSTG = 8;   // pipeline stages
    localparam int unsigned NDST = 4;   // live destinations

    ////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_GLOBAL    = 6'h00;
    localparam logic [5:0] IDX_START_CFG = 6'h02;
    localparam logic [5:0] IDX_GEAR      = 6'h12;
    localparam logic [5:0] IDX_PCMP      = 6'h32;
    localparam logic [5:0] IDX_TARGET    = 6'h37;
    localparam logic [5:0] IDX_STAGE0    = 6'h38;
    localparam logic [5:0] IDX_STAGE7    = 6'h3f;
    localparam logic [2:0] IDX_STAGE_HI  = 3'h7;  // index bits 5:3 of stages

    ////////////////////////////////////////////////////////////////////
    // start_configuration fields
    localparam int unsigned TSEL_LSB = 0;   // target select, 4 bits
    localparam int unsigned TSEL_W   = 4;
    localparam int unsigned WBS_LSB  = 8;   // writeback stage select
    localparam int unsigned WBS_W    = 8;

    // destination order inside the target select
    localparam int unsigned DST_TARGET = 0;
    localparam int unsigned DST_PCMP   = 1;
    localparam int unsigned DST_GEAR   = 2;
    localparam int unsigned DST_GLOBAL = 3;

    // segment depths by number of enabled destinations
    localparam logic [3:0] SEG_LEN_1 = 4'h8;
    localparam logic [3:0] SEG_LEN_2 = 4'h4;
    localparam logic [3:0] SEG_LEN_3 = 4'h3;
    localparam logic [3:0] SEG_LEN_4 = 4'h2;

    // reset value and axi responses
    localparam logic [DW-1:0] RST_WORD    = 32'h0000_0000;
    localparam logic [1:0]    RESP_OKAY   = 2'h0;
    localparam logic [1:0]    RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // axi4-lite carriers
    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [DW-1:0] wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } mpp_axi_req_t;

    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [DW-1:0] rdata;
        logic [1:0]    rresp;
    } mpp_axi_rsp_t;

    // whole state of the pipeline block
    typedef struct packed {
        logic [NDST-1:0][DW-1:0] live;
        logic [NSTG-1:0][DW-1:0] stage;
        logic [TSEL_W-1:0]       tsel;
        logic [WBS_W-1:0]        wbsel;
        logic                    aw_hold;
        logic [AW-1:0]           aw_addr;
        logic                    w_hold;
        logic [DW-1:0]           w_data;
        logic [3:0]              w_strb;
        logic                    awrdy;
        logic                    wrdy;
        logic                    arrdy;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [DW-1:0]           rdata;
        logic [1:0]              rresp;
    } mpp_state_t;

    // depth of each segment for a given enabled count
    function automatic logic [3:0] seg_len(input logic [2:0] n);
        case (n)
            3'h1:    seg_len = SEG_LEN_1;
            3'h2:    seg_len = SEG_LEN_2;
            3'h3:    seg_len = SEG_LEN_3;
            default: seg_len = SEG_LEN_4;
        endcase
    endfunction : seg_len

endpackage : mpp_pkg

// [mpp_seg_map.sv]
`timescale 1ns/1ns
// maps the target select onto segment heads, owners and tails
module mpp_seg_map #(
    parameter int unsigned NSTG = mpp_pkg::NSTG,
    parameter int unsigned NDST = mpp_pkg::NDST
) (
    // selection
    input  wire logic [NDST-1:0]                    tsel,
    // mapping
    output logic      [NDST-1:0][$clog2(NSTG)-1:0]  head,
    output logic      [NSTG-1:0][$clog2(NDST)-1:0]  owner,
    output logic      [NSTG-1:0]                    last
);

    localparam int unsigned SW = $clog2(NSTG);
    localparam int unsigned OW = $clog2(NDST);

    ////////////////////////////////////////////////////////////////////
    // heads in ascending bit order, owner is the last head at or below
    always_comb begin
        logic [2:0] cnt;
        logic [2:0] rank;
        logic [3:0] len;
        cnt  = '0;
        rank = '0;
        len  = '0;
        for (int d = 0; d < NDST; d++) begin
            cnt = cnt + 3'(tsel[d]);
        end
        len = mpp_pkg::seg_len(cnt);
        for (int d = 0; d < NDST; d++) begin
            head[d] = SW'(rank * len);  // heads k*depth
            rank    = rank + 3'(tsel[d]);
        end
        for (int s = 0; s < NSTG; s++) begin
            owner[s] = '0;
            for (int d = 0; d < NDST; d++) begin
                if (tsel[d] && (s >= int'(head[d]))) begin
                    owner[s] = OW'(d);
                end
            end
        end
        // a stage is a tail when the next stage has another owner
        for (int s = 0; s < NSTG - 1; s++) begin
            last[s] = (owner[s] != owner[s+1]);
        end
        last[NSTG-1] = 1'b1;
    end

endmodule : mpp_seg_map

// [mpp_param_pipe.sv]
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - start pulse shifts, target written back too
// - destination takes segment head, stages shift down
// - eight stages at indices 0x38..0x3f
// - destinations at 0x37, 0x32, 0x12, 0x00
// - one select bit enables one destination
// - segments equal set bits, none loads nothing
// - depths 8, 4+4, 3+3+2, 2+2+2+2
// - two enabled: heads at stages 0 and 4
// - three enabled: heads at stages 0, 3, 6
// - writeback into own segment makes it cyclic
// - writeback value picked by owning destination
module mpp_param_pipe (
    // clock and reset
    input  wire logic                                         aclk,
    input  wire logic                                         aresetn,
    // register bus
    input  wire mpp_pkg::mpp_axi_req_t                        axi_req,
    output mpp_pkg::mpp_axi_rsp_t                             axi_rsp,
    // internal start pulse
    input  wire logic                                         start_pulse,
    // live motion registers
    output logic [mpp_pkg::NDST-1:0][mpp_pkg::DW-1:0]         live_values
);

    localparam int unsigned NSTG = mpp_pkg::NSTG;
    localparam int unsigned NDST = mpp_pkg::NDST;
    localparam int unsigned DW   = mpp_pkg::DW;
    localparam int unsigned SW   = $clog2(NSTG);
    localparam int unsigned OW   = $clog2(NDST);

    mpp_pkg::mpp_state_t            st_q;      // registered state
    mpp_pkg::mpp_state_t            st_d;      // next state
    logic [NDST-1:0][SW-1:0]        head;      // segment head per destination
    logic [NSTG-1:0][OW-1:0]        owner;     // owning destination per stage
    logic [NSTG-1:0]                last;      // stage is a segment tail
    logic [NSTG-1:0][DW-1:0]        up;        // successor of each stage
    logic                           wr_fire;   // a bus write lands now
    logic [5:0]                     wr_idx;    // index of that write
    logic                           shift;     // pipeline shift now

    ////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane merge of a write into a stored word
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] nw,
                                            input logic [3:0]    strb);
        logic [DW-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // word index from a byte address
    function automatic logic [5:0] to_idx(
        input logic [mpp_pkg::AW-1:0] a);
        to_idx = a[7:2];
    endfunction : to_idx

    // read mux, top two bits carry the response code
    function automatic logic [DW+1:0] rd_word(input mpp_pkg::mpp_state_t s,
                                              input logic [5:0] i);
        logic [DW-1:0] w;
        w = '0;
        rd_word = {mpp_pkg::RESP_OKAY, mpp_pkg::RST_WORD};
        if (i[5:3] == mpp_pkg::IDX_STAGE_HI) begin
            rd_word[DW-1:0] = s.stage[i[2:0]];
        end else begin
            case (i)
                mpp_pkg::IDX_GLOBAL:
                    rd_word[DW-1:0] = s.live[mpp_pkg::DST_GLOBAL];
                mpp_pkg::IDX_GEAR:
                    rd_word[DW-1:0] = s.live[mpp_pkg::DST_GEAR];
                mpp_pkg::IDX_PCMP:
                    rd_word[DW-1:0] = s.live[mpp_pkg::DST_PCMP];
                mpp_pkg::IDX_TARGET:
                    rd_word[DW-1:0] = s.live[mpp_pkg::DST_TARGET];
                mpp_pkg::IDX_START_CFG: begin
                    w[mpp_pkg::TSEL_LSB +: mpp_pkg::TSEL_W] = s.tsel;
                    w[mpp_pkg::WBS_LSB  +: mpp_pkg::WBS_W]  = s.wbsel;
                    rd_word[DW-1:0] = w;
                end
                default:
                    rd_word[DW+1:DW] = mpp_pkg::RESP_SLVERR;
            endcase
        end
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////
    // segment mapping from the target select
    mpp_seg_map #(
        .NSTG (NSTG),
        .NDST (NDST)
    ) u_map (
        .tsel  (st_q.tsel),
        .head  (head),
        .owner (owner),
        .last  (last)
    );

    ////////////////////////////////////////////////////////////////////
    // next state: shift first, bus write after so software wins
    always_comb begin
        logic [DW-1:0] cfg;
        cfg     = '0;
        st_d    = st_q;
        up      = {st_q.stage[NSTG-1], st_q.stage[NSTG-1:1]};
        wr_idx  = to_idx(st_q.aw_addr);
        wr_fire = st_q.aw_hold && st_q.w_hold && !st_q.bvalid;
        shift   = start_pulse && (st_q.tsel != '0);

        // pipeline shift on the start pulse
        if (shift) begin
            for (int d = 0; d < NDST; d++) begin
                if (st_q.tsel[d]) begin
                    // destination loads its segment head
                    st_d.live[d] = st_q.stage[head[d]];
                end
            end
            for (int s = 0; s < NSTG; s++) begin
                if (st_q.wbsel[s]) begin
                    // old live value of the owning destination
                    st_d.stage[s] = st_q.live[owner[s]];
                end else if (!last[s]) begin
                    st_d.stage[s] = up[s];
                end
                // an unflagged tail keeps its contents
            end
        end

        // take write address and write data in either order
        if (axi_req.awvalid && st_q.awrdy) begin
            st_d.aw_hold = 1'b1;
            st_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_q.wrdy) begin
            st_d.w_hold = 1'b1;
            st_d.w_data = axi_req.wdata;
            st_d.w_strb = axi_req.wstrb;
        end

        // perform the write once both halves are held
        if (wr_fire) begin
            st_d.aw_hold = 1'b0;
            st_d.w_hold  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = mpp_pkg::RESP_OKAY;
            if (wr_idx[5:3] == mpp_pkg::IDX_STAGE_HI) begin
                // pipeline stage
                st_d.stage[wr_idx[2:0]] = merge(st_q.stage[wr_idx[2:0]],
                    st_q.w_data, st_q.w_strb);
            end else begin
                case (wr_idx)
                    // destination registers
                    mpp_pkg::IDX_GLOBAL:
                        st_d.live[mpp_pkg::DST_GLOBAL] =
                            merge(st_q.live[mpp_pkg::DST_GLOBAL],
                                  st_q.w_data, st_q.w_strb);
                    mpp_pkg::IDX_GEAR:
                        st_d.live[mpp_pkg::DST_GEAR] =
                            merge(st_q.live[mpp_pkg::DST_GEAR],
                                  st_q.w_data, st_q.w_strb);
                    mpp_pkg::IDX_PCMP:
                        st_d.live[mpp_pkg::DST_PCMP] =
                            merge(st_q.live[mpp_pkg::DST_PCMP],
                                  st_q.w_data, st_q.w_strb);
                    mpp_pkg::IDX_TARGET:
                        st_d.live[mpp_pkg::DST_TARGET] =
                            merge(st_q.live[mpp_pkg::DST_TARGET],
                                  st_q.w_data, st_q.w_strb);
                    // selection fields
                    mpp_pkg::IDX_START_CFG: begin
                        cfg[mpp_pkg::TSEL_LSB +: mpp_pkg::TSEL_W] =
                            st_q.tsel;
                        cfg[mpp_pkg::WBS_LSB +: mpp_pkg::WBS_W] =
                            st_q.wbsel;
                        cfg = merge(cfg, st_q.w_data, st_q.w_strb);
                        st_d.tsel  =
                            cfg[mpp_pkg::TSEL_LSB +: mpp_pkg::TSEL_W];
                        st_d.wbsel =
                            cfg[mpp_pkg::WBS_LSB +: mpp_pkg::WBS_W];
                    end
                    // unmapped index
                    default:
                        st_d.bresp = mpp_pkg::RESP_SLVERR;
                endcase
            end
        end else if (st_q.bvalid && axi_req.bready) begin
            st_d.bvalid = 1'b0;  // response accepted
        end

        // read channel, one read under way at a time
        if (axi_req.arvalid && st_q.arrdy) begin
            st_d.rvalid = 1'b1;
            {st_d.rresp, st_d.rdata} = rd_word(st_q,
                                               to_idx(axi_req.araddr));
        end else if (st_q.rvalid && axi_req.rready) begin
            st_d.rvalid = 1'b0;
        end

        // ready flags follow the next holding state
        st_d.awrdy = !st_d.aw_hold && !st_d.bvalid;
        st_d.wrdy  = !st_d.w_hold && !st_d.bvalid;
        st_d.arrdy = !st_d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    // one driver for the whole response struct
    assign axi_rsp = '{
        awready: st_q.awrdy,
        wready:  st_q.wrdy,
        bvalid:  st_q.bvalid,
        bresp:   st_q.bresp,
        arready: st_q.arrdy,
        rvalid:  st_q.rvalid,
        rdata:   st_q.rdata,
        rresp:   st_q.rresp
    };
    assign live_values     = st_q.live;

    ////////////////////////////////////////////////////////////////////
    // checks
    // every check samples at the bus clock and sleeps in reset;
    // shift checks exclude a landing write, which wins its register
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // target loads stage 0 on a lone target pipeline
    property p_target_load;
        start_pulse && st_q.tsel == 4'h1 && !wr_fire |=>
            st_q.live[0] == $past(st_q.stage[0]);
    endproperty
    a_target_load: assert property (p_target_load)
        else $error("target not loaded from stage 0");

    // writeback select 0x10 returns target into stage 4
    property p_wb_stage4;
        start_pulse && st_q.tsel == 4'h1 && st_q.wbsel == 8'h10
            && !wr_fire |=> st_q.stage[4] == $past(st_q.live[0]);
    endproperty
    a_wb_stage4: assert property (p_wb_stage4)
        else $error("target not written back to stage 4");

    // stages move down by one inside a segment
    property p_shift_down;
        start_pulse && st_q.tsel == 4'h1 && st_q.wbsel == 8'h00
            && !wr_fire |=> st_q.stage[2] == $past(st_q.stage[3]);
    endproperty
    a_shift_down: assert property (p_shift_down)
        else $error("stage 2 did not take stage 3");

    // nothing loads with an empty select
    property p_no_load;
        start_pulse && st_q.tsel == 4'h0 && !wr_fire |=>
            $stable(st_q.live) && $stable(st_q.stage);
    endproperty
    a_no_load: assert property (p_no_load)
        else $error("empty select changed registers");

    // two segments fed from stages 0 and 4
    property p_two_seg;
        start_pulse && st_q.tsel == 4'h6 && !wr_fire |=>
            st_q.live[1] == $past(st_q.stage[0]) &&
            st_q.live[2] == $past(st_q.stage[4]);
    endproperty
    a_two_seg: assert property (p_two_seg)
        else $error("two segment heads wrong");

    // three segments fed from stages 0, 3 and 6
    property p_three_seg;
        start_pulse && st_q.tsel == 4'hd && !wr_fire |=>
            st_q.live[0] == $past(st_q.stage[0]) &&
            st_q.live[2] == $past(st_q.stage[3]) &&
            st_q.live[3] == $past(st_q.stage[6]);
    endproperty
    a_three_seg: assert property (p_three_seg)
        else $error("three segment heads wrong");

    // four segments of two, tails keep their value
    property p_four_seg;
        start_pulse && st_q.tsel == 4'hf && st_q.wbsel == 8'h00
            && !wr_fire |=>
            st_q.live[1] == $past(st_q.stage[2]) &&
            st_q.live[2] == $past(st_q.stage[4]) &&
            st_q.stage[4] == $past(st_q.stage[5]) &&
            st_q.stage[5] == $past(st_q.stage[5]);
    endproperty
    a_four_seg: assert property (p_four_seg)
        else $error("four segment shift wrong");

    // writeback into stage 6 takes the second destination
    property p_wb_owner;
        start_pulse && st_q.tsel == 4'h3 && st_q.wbsel == 8'h40
            && !wr_fire |=> st_q.stage[6] == $past(st_q.live[1]);
    endproperty
    a_wb_owner: assert property (p_wb_owner)
        else $error("writeback source wrong");

    // write taken in one cycle is answered two edges later
    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready &&
        axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_wr_ans;
        ##2 axi_rsp.bvalid;
    endsequence
    property p_wr_resp;
        s_wr_take |-> s_wr_ans;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");

    // read answered at the next edge
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    property p_rd_resp;
        s_rd_take |=> axi_rsp.rvalid && !axi_rsp.arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response late");

endmodule : mpp_param_pipe

// [tb.sv]
`timescale 1ns/1ns
module tb;

    ////////////////////////////////////////////////////////////////////
    // signals
    logic                  aclk;         // system clock
    logic                  aresetn;      // sync reset, low active
    mpp_pkg::mpp_axi_req_t req;          // bus request
    mpp_pkg::mpp_axi_rsp_t rsp;          // bus response
    logic                  start_pulse;  // internal start
    logic [3:0][31:0]      live;         // live register outputs
    logic [31:0]           m_stage [8];  // expected stages
    logic [31:0]           m_live  [4];  // expected live values
    logic [5:0]            didx    [4];  // live register indices
    logic [31:0]           rd;           // last read data
    logic [1:0]            rs;           // last response code
    logic [3:0]            ts;           // target select in use
    logic [7:0]            wb;           // writeback select in use
    int                    error_cnt;    // mismatches
    int                    checks;       // comparisons

    ////////////////////////////////////////////////////////////////////
    // design
    mpp_param_pipe i_mpp_param_pipe (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .axi_req     (req),
        .axi_rsp     (rsp),
        .start_pulse (start_pulse),
        .live_values (live)
    );

    // 50 mhz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////
    // helpers
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // one bus write, response code left in rs
    task automatic axw(input logic [5:0] idx, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b0;
        w  = 1'b0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= {idx, 2'b00};
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        // hold each channel until its own ready
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && rsp.awready) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!w && rsp.wready) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!rsp.bvalid);
        rs = rsp.bresp;
        req.bready <= 1'b0;
    endtask : axw

    // one bus read, data in rd and code in rs
    task automatic axr(input logic [5:0] idx);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= {idx, 2'b00};
        req.rready  <= 1'b1;
        do @(posedge aclk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (!rsp.rvalid);
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axr

    // expected effect of one start pulse
    task automatic mshift();
        logic [31:0] ol [4];
        logic [31:0] os [8];
        int          ds [4];
        int          hd [4];
        int          n;
        int          k;
        int          ln;
        n  = 0;
        ol = m_live;
        os = m_stage;
        for (int d = 0; d < 4; d++) begin
            if (ts[d]) begin
                ds[n] = d;
                n++;
            end
        end
        if (n == 0) return;
        ln = (n == 1) ? 8 : (n == 2) ? 4 : (n == 3) ? 3 : 2;
        // heads in ascending select bit order
        for (k = 0; k < n; k++) begin
            hd[k] = k * ln;
            m_live[ds[k]] = os[hd[k]];
        end
        // writeback, shift down, tails keep
        for (int s = 0; s < 8; s++) begin
            k = 0;
            while (k + 1 < n && s >= hd[k + 1]) k++;
            if (wb[s]) begin
                m_stage[s] = ol[ds[k]];
            end else if (s < 7 && !(k + 1 < n && s + 1 == hd[k + 1])) begin
                m_stage[s] = os[s + 1];
            end
        end
    endtask : mshift

    // one start pulse, model follows
    task automatic pulse();
        @(posedge aclk);
        start_pulse <= 1'b1;
        @(posedge aclk);
        start_pulse <= 1'b0;
        mshift();
    endtask : pulse

    // read back all stages and live registers
    task automatic check_all();
        for (int s = 0; s < 8; s++) begin
            axr(6'(mpp_pkg::IDX_STAGE0 + s));
            chk(rd, m_stage[s]);
        end
        for (int d = 0; d < 4; d++) begin
            axr(didx[d]);
            chk(rd, m_live[d]);
            chk(live[d], m_live[d]);
        end
    endtask : check_all

    ////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the expected run
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        req         = '0;
        start_pulse = 1'b0;
        aresetn     = 1'b0;
        error_cnt   = 0;
        checks      = 0;
        ts          = 4'h0;
        wb          = 8'h00;
        didx = '{mpp_pkg::IDX_TARGET, mpp_pkg::IDX_PCMP,
                 mpp_pkg::IDX_GEAR, mpp_pkg::IDX_GLOBAL};
        foreach (m_stage[s]) m_stage[s] = 32'h0;
        foreach (m_live[d]) m_live[d] = 32'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // everything cleared by reset
        check_all();
        // unmapped index answers with an error
        axw(6'h01, 32'hffff_ffff);
        chk({30'h0, rs}, {30'h0, mpp_pkg::RESP_SLVERR});
        axr(6'h01);
        chk({30'h0, rs}, {30'h0, mpp_pkg::RESP_SLVERR});
        // distinct live values so writeback is visible
        for (int d = 0; d < 4; d++) begin
            m_live[d] = {8'h1d, 24'(d)};
            axw(didx[d], m_live[d]);
        end
        // every select code, then one and four segments again
        for (int t = 0; t < 18; t++) begin
            ts = (t < 16) ? 4'(t) : (t == 16) ? 4'h1 : 4'hf;
            wb = (t == 1) ? 8'h10 : (t == 3) ? 8'h40 :
                 (t == 15 || t == 16) ? 8'h00 : 8'h01 << (t % 8);
            for (int s = 0; s < 8; s++) begin
                m_stage[s] = {4'(t), 4'(s), 24'h3c5a96};
                axw(6'(mpp_pkg::IDX_STAGE0 + s), m_stage[s]);
            end
            axw(mpp_pkg::IDX_START_CFG, {16'h0, wb, 4'h0, ts});
            axr(mpp_pkg::IDX_START_CFG);
            chk(rd, {16'h0, wb, 4'h0, ts});
            // two shifts, one idle cycle apart, show the cycle
            pulse();
            pulse();
            check_all();
        end
        report_and_stop();
    end

endmodule : tb
